//--- dv/sc_far_device.sv
`timescale 1ns/1ps
module sc_far_device (
	input wire logic clk_i,
	input wire logic slow_i,
	input wire logic [7:0] core_pin_i,
	input wire logic [7:0] core_oe_n_i,
	output logic [7:0] pin_level_o
);
	logic [7:0] line;
	logic late_reg;
	////////////////////////////////////////////////////////////
	// Undriven lines float high on their pull-ups
	assign line = core_pin_i | core_oe_n_i;
	// Echo delay for the slow answer
	always @(posedge clk_i) begin
		late_reg <= line[0];
	end
	// Line 1 returns line 0, at once or a cycle late
	assign pin_level_o = {line[7:2], slow_i ? late_reg : line[0], line[0]};
endmodule // sc_far_device

//--- dv/sc_serial_core_properties.sv
`timescale 1ns/1ps
`include "sc_regs.svh"
module sc_serial_core_properties (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic soft_reset_request_i,
	input wire logic debug_hold_bit_i,
	input wire logic core_halted_i,
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe_n_o,
	input wire logic [3:0][1:0] shifter_mode_i,
	input wire logic [3:0][2:0] shifter_pin_select_i,
	input wire logic [3:0][1:0] shifter_stop_bit_setting_i,
	input wire logic [3:0][1:0] timer_operating_mode_i,
	input wire logic [3:0][1:0] timer_decrement_source_i,
	input wire logic [3:0][15:0] timer_compare_i,
	input wire logic [3:0] shifter_ready_clear_i,
	input wire logic [3:0] timer_event_clear_i,
	input wire logic [3:0] shifter_ready_irq_enable_i,
	input wire logic [3:0] shifter_fault_irq_enable_i,
	input wire logic [3:0] timer_event_irq_enable_i,
	input wire logic [3:0] shifter_ready_flag_o,
	input wire logic [3:0] shifter_fault_flag_o,
	input wire logic [3:0] timer_event_flag_o,
	input wire logic [3:0] shifter_ready_irq_o,
	input wire logic [3:0] shifter_fault_irq_o,
	input wire logic [3:0] timer_event_irq_o,
	input wire logic [3:0] dma_req_o,
	input wire logic [3:0] timer_out_o
);
	// All checks share the module clock and the system reset
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////
	// Interrupt and request outputs follow their flags
	AST_IRQ_READY: assert property (shifter_ready_irq_o == (shifter_ready_flag_o & shifter_ready_irq_enable_i))
		else $error("ready irq differs from flag and enable");
	AST_IRQ_FAULT: assert property (shifter_fault_irq_o == (shifter_fault_flag_o & shifter_fault_irq_enable_i))
		else $error("fault irq differs from flag and enable");
	AST_IRQ_TIMER: assert property (timer_event_irq_o == (timer_event_flag_o & timer_event_irq_enable_i))
		else $error("timer irq differs from flag and enable");
	AST_DMA_READY: assert property (dma_req_o == shifter_ready_flag_o)
		else $error("dma request differs from ready flag");
	// Timer event and shifter ready flags hold until cleared
	AST_TIMER_FLAG_HOLD: assert property (!soft_reset_request_i |=>
		(($past(timer_event_flag_o) & ~$past(timer_event_clear_i) & ~timer_event_flag_o) == 4'h0))
		else $error("timer flag dropped without clear");
	AST_READY_FLAG_HOLD: assert property (!soft_reset_request_i |=>
		(($past(shifter_ready_flag_o) & ~$past(shifter_ready_clear_i) & ~shifter_ready_flag_o) == 4'h0))
		else $error("ready flag dropped without clear");
	// Soft reset returns state to default
	AST_SOFT_RESET: assert property (soft_reset_request_i |=> (shifter_ready_flag_o == 4'h0) &&
		(shifter_fault_flag_o == 4'h0) && (timer_event_flag_o == 4'h0) && (timer_out_o == 4'h0))
		else $error("state not cleared by soft reset");
	// Debug halt without hold freezes the block
	AST_HALT_FREEZE: assert property (core_halted_i && !debug_hold_bit_i && !soft_reset_request_i |=>
		$stable(timer_out_o) && $stable(pin_o))
		else $error("block moved during halt");
	// Timer 1 never raises its event while disabled
	AST_OFF_NO_EVENT: assert property ($rose(timer_event_flag_o[1]) |->
		$past(timer_operating_mode_i[1]) != `TMR_MODE_OFF)
		else $error("event from a timer that is off");
	// Sixteen-bit count of two toggles every third cycle
	AST_T16_PERIOD: assert property (disable iff (!rst_n_i || soft_reset_request_i || core_halted_i ||
		timer_operating_mode_i[0] != `TMR_MODE_16)
		$changed(timer_out_o[0]) && timer_decrement_source_i[0] == `TMR_DEC_CLK && timer_compare_i[0] == 16'h0002
		|=> $stable(timer_out_o[0]) [*2] ##1 $changed(timer_out_o[0]))
		else $error("sixteen-bit period wrong");
	// Entering transmit drives the stop level and sets ready
	AST_TX_ENTRY: assert property (shifter_mode_i[0] == `SHF_MODE_TX && $past(shifter_mode_i[0]) != `SHF_MODE_TX &&
		shifter_stop_bit_setting_i[0] == 2'h3 && !soft_reset_request_i |-> ##[1:2]
		(pin_o[shifter_pin_select_i[0]] && !pin_oe_n_o[shifter_pin_select_i[0]] && shifter_ready_flag_o[0]))
		else $error("transmit entry wrong");
endmodule // sc_serial_core_properties

bind sc_serial_core sc_serial_core_properties sc_serial_core_properties_i (.*);

//--- dv/tb.sv
`timescale 1ns/1ps
`include "sc_regs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; $display("MISMATCH time=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
	logic clk_i, rst_n_i, soft_reset_request_i, debug_hold_bit_i, core_halted_i, slow, rx_open, v;
	logic [7:0] pin_i, pin_o, pin_oe_n_o;
	logic [3:0] shifter_input_source_i, tx_valid_i, tx_ready_o, rx_valid_o;
	logic [3:0] ext_trigger_i = 4'h0;
	logic [3:0] rx_ready_i = 4'h0;
	logic [3:0][1:0] shifter_mode_i, shifter_timer_select_i, shifter_start_bit_setting_i, shifter_stop_bit_setting_i;
	logic [3:0][2:0] shifter_pin_select_i, timer_pin_select_i;
	logic [3:0][31:0] tx_data_i, rx_data_o;
	logic [3:0][1:0] timer_operating_mode_i, timer_decrement_source_i, timer_enable_mode_i;
	logic [3:0][4:0] timer_trigger_select_i;
	logic [3:0] timer_reset_on_trigger_i, timer_pin_drive_i, timer_output_initial_state_i;
	logic [3:0] timer_start_bit_setting_i, timer_stop_bit_setting_i;
	logic [3:0][15:0] timer_compare_i;
	logic [3:0] shifter_ready_clear_i, shifter_fault_clear_i, timer_event_clear_i;
	logic [3:0] shifter_ready_irq_enable_i, shifter_fault_irq_enable_i, timer_event_irq_enable_i;
	logic [3:0] shifter_ready_flag_o, shifter_fault_flag_o, timer_event_flag_o;
	logic [3:0] shifter_ready_irq_o, shifter_fault_irq_o, timer_event_irq_o, dma_req_o, timer_out_o;
	logic [31:0] w [4];
	logic [31:0] q [$];
	int comparisons = 0;
	int num_errors = 0;
	int cycles = 0;
	int seed = 86825;
	int n, k;

	sc_serial_core sc_serial_core_i (.*);
	sc_far_device sc_far_device_i (.clk_i(clk_i), .slow_i(slow), .core_pin_i(pin_o), .core_oe_n_i(pin_oe_n_o),
		.pin_level_o(pin_i));
	////////////////////////////////////////////////////////////
	// Clock, cycle ceiling and background traffic
	always #20 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			close_out();
		end
	end
	always @(posedge clk_i) begin
		if (rx_valid_o[1] === 1'b1 && rx_ready_i[1] === 1'b1) begin
			q.push_back(rx_data_o[1]);
		end
		#1;
		rx_ready_i[1] <= rx_open & 1'($random(seed));
		if (cycles % 4 == 0) begin
			ext_trigger_i <= 4'($random(seed));
		end
	end
	////////////////////////////////////////////////////////////
	// Helpers
	task automatic tick(input int c);
		repeat (c) @(posedge clk_i);
		#1;
	endtask
	function automatic int span(input int c);
		return c + 1;
	endfunction
	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask
	task automatic run_len(input int t, input logic lvl, output int len);
		int c;
		len = 0;
		c = 0;
		while (timer_out_o[t] === lvl && c < 600) begin tick(1); c++; end
		while (timer_out_o[t] !== lvl && c < 600) begin tick(1); c++; end
		while (timer_out_o[t] === lvl && c < 600) begin tick(1); c++; len++; end
	endtask
	task automatic push(input logic [31:0] d);
		int c;
		c = 0;
		while (tx_ready_o[0] !== 1'b1 && c < 2000) begin tick(1); c++; end
		tx_data_i[0] = d;
		tx_valid_i[0] = 1'b1;
		tick(1);
		tx_valid_i[0] = 1'b0;
		tick(1);
	endtask
	task automatic close_out();
		$display("comparisons=%0d mismatches=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		clk_i = 1'b0;
		rst_n_i = 1'b0;
		slow = 1'b1;
		rx_open = 1'b0;
		{soft_reset_request_i, debug_hold_bit_i, core_halted_i, shifter_mode_i, shifter_pin_select_i,
			shifter_input_source_i, shifter_timer_select_i, shifter_start_bit_setting_i, shifter_stop_bit_setting_i,
			tx_data_i, tx_valid_i, timer_operating_mode_i, timer_decrement_source_i, timer_enable_mode_i,
			timer_trigger_select_i, timer_reset_on_trigger_i, timer_pin_select_i, timer_pin_drive_i,
			timer_output_initial_state_i, timer_start_bit_setting_i, timer_stop_bit_setting_i, timer_compare_i,
			shifter_ready_clear_i, shifter_fault_clear_i, timer_event_clear_i, shifter_ready_irq_enable_i,
			shifter_fault_irq_enable_i, timer_event_irq_enable_i} = '0;
		tick(16);
		rst_n_i = 1'b1;
		`CHK({shifter_ready_flag_o, shifter_fault_flag_o, timer_event_flag_o, timer_out_o}, 16'h0)
		{shifter_ready_irq_enable_i, shifter_fault_irq_enable_i, timer_event_irq_enable_i} = 12'($random(seed));
		end_test("reset");
		// Sixteen-bit count on every clock
		timer_compare_i[0] = 16'h0002;
		timer_operating_mode_i[0] = `TMR_MODE_16;
		run_len(0, 1'b1, n);
		`CHK(n, span(2))
		run_len(0, 1'b0, n);
		`CHK(n, span(2))
		`CHK(timer_event_flag_o[0], 1'b1)
		timer_operating_mode_i[0] = `TMR_MODE_OFF;
		end_test("count16");
		// Pulse width with initial and start settings that must not matter
		timer_compare_i[1] = 16'h0204;
		timer_start_bit_setting_i[1] = 1'b1;
		timer_operating_mode_i[1] = `TMR_MODE_PWM;
		run_len(1, 1'b1, n);
		`CHK(n, span(4))
		run_len(1, 1'b0, n);
		`CHK(n, span(2))
		`CHK(timer_event_flag_o[1], 1'b1)
		// Debug halt, with and without hold
		core_halted_i = 1'b1;
		v = timer_out_o[1];
		tick(6);
		`CHK(timer_out_o[1], v)
		debug_hold_bit_i = 1'b1;
		run_len(1, 1'b1, n);
		`CHK(n, span(4))
		core_halted_i = 1'b0;
		debug_hold_bit_i = 1'b0;
		timer_operating_mode_i[1] = `TMR_MODE_OFF;
		tick(2);
		timer_event_clear_i[1] = 1'b1;
		tick(1);
		timer_event_clear_i[1] = 1'b0;
		`CHK(timer_event_flag_o[1], 1'b0)
		end_test("pwm_halt");
		// Transmit on line 0, receive its echo on line 1
		shifter_pin_select_i[1] = 3'h1;
		shifter_stop_bit_setting_i[0] = 2'h3;
		shifter_mode_i[1] = `SHF_MODE_RX;
		shifter_mode_i[0] = `SHF_MODE_TX;
		tick(3);
		`CHK(shifter_ready_flag_o[0], 1'b1)
		`CHK({pin_o[0], pin_oe_n_o[0]}, 2'b10)
		shifter_ready_clear_i[0] = 1'b1;
		tick(1);
		shifter_ready_clear_i[0] = 1'b0;
		tick(1);
		`CHK(shifter_ready_flag_o[0], 1'b0)
		for (int i = 0; i < 4; i++) w[i] = $random(seed);
		push(w[0]);
		push(w[1]);
		`CHK(tx_ready_o[0], 1'b0)
		timer_compare_i[0] = 16'h3f03;
		timer_decrement_source_i[0] = `TMR_DEC_CLK;
		timer_operating_mode_i[0] = `TMR_MODE_BAUD;
		rx_open = 1'b1;
		push(w[2]);
		push(w[3]);
		k = 0;
		while (q.size() < 5 && k < 3000) begin tick(1); k++; end
		tick(4);
		`CHK(shifter_ready_flag_o[1:0], 2'b11)
		`CHK(shifter_fault_flag_o[1:0], 2'b01)
		k = -1;
		foreach (q[j]) if (k < 0 && q[j] === w[0]) k = j;
		for (int i = 0; i < 4; i++) `CHK(q[k + i], w[i])
		rx_open = 1'b0;
		tick(1100);
		`CHK(shifter_fault_flag_o[1], 1'b1)
		end_test("serial");
		// Soft reset clears flags and buffers
		soft_reset_request_i = 1'b1;
		tick(1);
		`CHK({shifter_ready_flag_o, shifter_fault_flag_o, timer_event_flag_o, rx_valid_o}, 16'h0)
		soft_reset_request_i = 1'b0;
		end_test("soft_reset");
		close_out();
	end
endmodule // tb

//--- hdl/sc_pair_buffer.sv
`timescale 1ns/1ps
module sc_pair_buffer import sc_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic flush_i,
	input wire logic [`SC_DATA_W-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [`SC_DATA_W-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i
);
	buf_state_t state_reg;
	buf_state_t state_next;
	logic push;
	logic pop;

	// Handshakes follow the fill level
	assign in_ready_o = (state_reg.cnt != 2'h2);
	assign out_valid_o = (state_reg.cnt != 2'h0);
	assign out_data_o = state_reg.mem[state_reg.rptr];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// Pointer and level update
	always_comb begin
		state_next = state_reg;
		if (push) begin
			state_next.mem[state_reg.wptr] = in_data_i;
			state_next.wptr = ~state_reg.wptr;
		end
		if (pop) begin
			state_next.rptr = ~state_reg.rptr;
		end
		if (push && !pop) begin
			state_next.cnt = state_reg.cnt + 2'h1;
		end else if (pop && !push) begin
			state_next.cnt = state_reg.cnt - 2'h1;
		end
	end

	// State register, flushed by either reset
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || flush_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end
endmodule // sc_pair_buffer

//--- hdl/sc_pkg.sv
`include "sc_regs.svh"

package sc_pkg;

	// One timer's state
	typedef struct packed {
		logic [15:0] cnt;
		logic out;
		logic en;
		logic trig_q;
		logic pin_q;
		logic flag;
	} timer_t;

	// One shifter's state
	typedef struct packed {
		logic [`SC_DATA_W-1:0] sreg;
		logic out;
		logic [1:0] mode_q;
		logic first;
		logic ready;
		logic fault;
	} shifter_t;

	// Whole core state
	typedef struct packed {
		timer_t [`SC_NTMR-1:0] tmr;
		shifter_t [`SC_NSHF-1:0] shf;
		logic [`SC_NPIN-1:0] pin_q;
		logic [`SC_NTMR-1:0] ext_s1;
		logic [`SC_NTMR-1:0] ext_s2;
	} core_state_t;

	// Two-entry buffer state
	typedef struct packed {
		logic [`SC_BUF_DEPTH-1:0][`SC_DATA_W-1:0] mem;
		logic wptr;
		logic rptr;
		logic [1:0] cnt;
	} buf_state_t;

endpackage

//--- hdl/sc_regs.svh
`ifndef SC_REGS_SVH
`define SC_REGS_SVH

// Block dimensions
`define SC_NSHF 4
`define SC_NTMR 4
`define SC_NPIN 8
`define SC_DATA_W 32
`define SC_TRG_W 20
`define SC_BUF_DEPTH 2

// Shifter mode codes
`define SHF_MODE_OFF 2'h0
`define SHF_MODE_RX 2'h1
`define SHF_MODE_TX 2'h2

// Timer operating mode codes
`define TMR_MODE_OFF 2'h0
`define TMR_MODE_BAUD 2'h1
`define TMR_MODE_PWM 2'h2
`define TMR_MODE_16 2'h3

// Timer decrement source codes
`define TMR_DEC_CLK 2'h0
`define TMR_DEC_TRIG 2'h1
`define TMR_DEC_PIN 2'h2
`define TMR_DEC_PIN_RISE 2'h3

// Timer enable condition codes
`define TMR_EN_ALWAYS 2'h0
`define TMR_EN_TRIG_HIGH 2'h1
`define TMR_EN_PREV 2'h2
`define TMR_EN_TRIG_RISE 2'h3

// Start and stop setting fields: bit 1 enables, bit 0 is the bit value
`define BIT_SET_EN 1
`define BIT_SET_VAL 0

// Trigger vector layout
`define TRG_TMR_BASE 0
`define TRG_PIN_BASE 4
`define TRG_FLAG_BASE 12
`define TRG_EXT_BASE 16

// Byte fields of the timer counter
`define CNT_LO 7:0
`define CNT_HI 15:8

`endif

//--- hdl/sc_serial_core.sv
`timescale 1ns/1ps
module sc_serial_core import sc_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic soft_reset_request_i,
	input wire logic debug_hold_bit_i,
	input wire logic core_halted_i,
	input wire logic [`SC_NPIN-1:0] pin_i,
	output logic [`SC_NPIN-1:0] pin_o,
	output logic [`SC_NPIN-1:0] pin_oe_n_o,
	input wire logic [`SC_NTMR-1:0] ext_trigger_i,
	input wire logic [`SC_NSHF-1:0][1:0] shifter_mode_i,
	input wire logic [`SC_NSHF-1:0][2:0] shifter_pin_select_i,
	input wire logic [`SC_NSHF-1:0] shifter_input_source_i,
	input wire logic [`SC_NSHF-1:0][1:0] shifter_timer_select_i,
	input wire logic [`SC_NSHF-1:0][1:0] shifter_start_bit_setting_i,
	input wire logic [`SC_NSHF-1:0][1:0] shifter_stop_bit_setting_i,
	input wire logic [`SC_NSHF-1:0][`SC_DATA_W-1:0] tx_data_i,
	input wire logic [`SC_NSHF-1:0] tx_valid_i,
	output logic [`SC_NSHF-1:0] tx_ready_o,
	output logic [`SC_NSHF-1:0][`SC_DATA_W-1:0] rx_data_o,
	output logic [`SC_NSHF-1:0] rx_valid_o,
	input wire logic [`SC_NSHF-1:0] rx_ready_i,
	input wire logic [`SC_NTMR-1:0][1:0] timer_operating_mode_i,
	input wire logic [`SC_NTMR-1:0][1:0] timer_decrement_source_i,
	input wire logic [`SC_NTMR-1:0][1:0] timer_enable_mode_i,
	input wire logic [`SC_NTMR-1:0][4:0] timer_trigger_select_i,
	input wire logic [`SC_NTMR-1:0] timer_reset_on_trigger_i,
	input wire logic [`SC_NTMR-1:0][2:0] timer_pin_select_i,
	input wire logic [`SC_NTMR-1:0] timer_pin_drive_i,
	input wire logic [`SC_NTMR-1:0] timer_output_initial_state_i,
	input wire logic [`SC_NTMR-1:0] timer_start_bit_setting_i,
	input wire logic [`SC_NTMR-1:0] timer_stop_bit_setting_i,
	input wire logic [`SC_NTMR-1:0][15:0] timer_compare_i,
	input wire logic [`SC_NSHF-1:0] shifter_ready_clear_i,
	input wire logic [`SC_NSHF-1:0] shifter_fault_clear_i,
	input wire logic [`SC_NTMR-1:0] timer_event_clear_i,
	input wire logic [`SC_NSHF-1:0] shifter_ready_irq_enable_i,
	input wire logic [`SC_NSHF-1:0] shifter_fault_irq_enable_i,
	input wire logic [`SC_NTMR-1:0] timer_event_irq_enable_i,
	output logic [`SC_NSHF-1:0] shifter_ready_flag_o,
	output logic [`SC_NSHF-1:0] shifter_fault_flag_o,
	output logic [`SC_NTMR-1:0] timer_event_flag_o,
	output logic [`SC_NSHF-1:0] shifter_ready_irq_o,
	output logic [`SC_NSHF-1:0] shifter_fault_irq_o,
	output logic [`SC_NTMR-1:0] timer_event_irq_o,
	output logic [`SC_NSHF-1:0] dma_req_o,
	output logic [`SC_NTMR-1:0] timer_out_o
);
	core_state_t state_reg;
	core_state_t state_next;
	logic run;
	logic [`SC_TRG_W-1:0] trig_vec;
	logic [`SC_NTMR-1:0] cmp;
	logic [`SC_NTMR-1:0] rise;
	logic [`SC_NTMR-1:0] fall;
	logic [`SC_NSHF-1:0] shf_in;
	logic [`SC_NSHF-1:0] tx_pop;
	logic [`SC_NSHF-1:0] tx_avail;
	logic [`SC_NSHF-1:0][`SC_DATA_W-1:0] tx_word;
	logic [`SC_NSHF-1:0] rx_push;
	logic [`SC_NSHF-1:0] rx_space;

	////////////////////////////////////////////////////////////////////////
	// Shared signals

	// Core stops during debug halt unless held running
	assign run = debug_hold_bit_i | ~core_halted_i;

	// Trigger sources: timer outputs, pins, ready flags, synced triggers
	always_comb begin
		trig_vec = '0;
		for (int i = 0; i < `SC_NTMR; i++) begin
			trig_vec[`TRG_TMR_BASE + i] = state_reg.tmr[i].out;
			trig_vec[`TRG_FLAG_BASE + i] = state_reg.shf[i].ready;
			trig_vec[`TRG_EXT_BASE + i] = state_reg.ext_s2[i];
		end
		trig_vec[`TRG_PIN_BASE +: `SC_NPIN] = state_reg.pin_q;
	end

	////////////////////////////////////////////////////////////////////////
	// Per-shifter buffers and input routing

	generate
		for (genvar s = 0; s < `SC_NSHF; s++) begin : g_shf
			// Serial input from a pin or from the neighbouring shifter
			assign shf_in[s] = shifter_input_source_i[s] ?
				state_reg.shf[(s + 1) % `SC_NSHF].out : state_reg.pin_q[shifter_pin_select_i[s]];

			// Transmit buffer, filled by software, drained on load
			sc_pair_buffer u_tx_buf (
				.clk_i(clk_i),
				.rst_n_i(rst_n_i),
				.flush_i(soft_reset_request_i),
				.in_data_i(tx_data_i[s]),
				.in_valid_i(tx_valid_i[s]),
				.in_ready_o(tx_ready_o[s]),
				.out_data_o(tx_word[s]),
				.out_valid_o(tx_avail[s]),
				.out_ready_i(tx_pop[s])
			);

			// Receive buffer, filled on store, drained by software
			sc_pair_buffer u_rx_buf (
				.clk_i(clk_i),
				.rst_n_i(rst_n_i),
				.flush_i(soft_reset_request_i),
				.in_data_i(state_reg.shf[s].sreg),
				.in_valid_i(rx_push[s]),
				.in_ready_o(rx_space[s]),
				.out_data_o(rx_data_o[s]),
				.out_valid_o(rx_valid_o[s]),
				.out_ready_i(rx_ready_i[s])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always_comb begin
		timer_t tm;
		shifter_t sh;
		logic trg;
		logic dpin;
		logic en;
		logic dec;
		logic set_rdy;
		logic set_flt;
		logic chk_st;
		logic chk_sp;
		logic [1:0] ts;
		tm = '0;
		sh = '0;
		trg = 1'b0;
		dpin = 1'b0;
		en = 1'b0;
		dec = 1'b0;
		set_rdy = 1'b0;
		set_flt = 1'b0;
		chk_st = 1'b0;
		chk_sp = 1'b0;
		ts = 2'h0;
		state_next = state_reg;
		cmp = '0;
		rise = '0;
		fall = '0;
		tx_pop = '0;
		rx_push = '0;
		state_next.pin_q = pin_i;
		state_next.ext_s1 = ext_trigger_i;
		state_next.ext_s2 = state_reg.ext_s1;

		// Timers
		for (int t = 0; t < `SC_NTMR; t++) begin
			tm = state_reg.tmr[t];
			trg = (timer_trigger_select_i[t] < 5'(`SC_TRG_W)) ? trig_vec[timer_trigger_select_i[t]] : 1'b0;
			dpin = state_reg.pin_q[timer_pin_select_i[t]];
			case (timer_enable_mode_i[t])
				`TMR_EN_ALWAYS: en = 1'b1;
				`TMR_EN_TRIG_HIGH: en = trg;
				`TMR_EN_PREV: en = state_reg.tmr[(t + `SC_NTMR - 1) % `SC_NTMR].en;
				default: en = tm.en | (trg & ~tm.trig_q);
			endcase
			en = en & (timer_operating_mode_i[t] != `TMR_MODE_OFF);
			case (timer_decrement_source_i[t])
				`TMR_DEC_CLK: dec = 1'b1;
				`TMR_DEC_TRIG: dec = trg ^ tm.trig_q;
				`TMR_DEC_PIN: dec = dpin ^ tm.pin_q;
				default: dec = dpin & ~tm.pin_q;
			endcase
			if (!en) begin
				tm.en = 1'b0;
				tm.out = 1'b0;
				tm.cnt = timer_compare_i[t];
			end else if (!tm.en) begin
				// Start: load compare, set initial output level
				tm.en = 1'b1;
				tm.cnt = timer_compare_i[t];
				if (timer_operating_mode_i[t] == `TMR_MODE_PWM) begin
					tm.out = 1'b1;
				end else begin
					tm.out = timer_output_initial_state_i[t];
				end
			end else if (timer_reset_on_trigger_i[t] && trg && !tm.trig_q) begin
				if (timer_operating_mode_i[t] == `TMR_MODE_BAUD) begin
					tm.cnt[`CNT_LO] = timer_compare_i[t][`CNT_LO];
				end else begin
					tm.cnt = timer_compare_i[t];
				end
			end else if (dec) begin
				case (timer_operating_mode_i[t])
					`TMR_MODE_BAUD: begin
						if (tm.cnt[`CNT_LO] == 8'h00) begin
							tm.out = ~tm.out;
							tm.cnt[`CNT_LO] = timer_compare_i[t][`CNT_LO];
							if (tm.cnt[`CNT_HI] == 8'h00) begin
								cmp[t] = 1'b1;
								tm.cnt[`CNT_HI] = timer_compare_i[t][`CNT_HI];
							end else begin
								tm.cnt[`CNT_HI] = tm.cnt[`CNT_HI] - 8'h01;
							end
						end else begin
							tm.cnt[`CNT_LO] = tm.cnt[`CNT_LO] - 8'h01;
						end
					end
					`TMR_MODE_PWM: begin
						if (tm.out) begin
							if (tm.cnt[`CNT_LO] == 8'h00) begin
								tm.out = 1'b0;
								tm.cnt[`CNT_LO] = timer_compare_i[t][`CNT_LO];
							end else begin
								tm.cnt[`CNT_LO] = tm.cnt[`CNT_LO] - 8'h01;
							end
						end else if (tm.cnt[`CNT_HI] == 8'h00) begin
							tm.out = 1'b1;
							tm.cnt[`CNT_HI] = timer_compare_i[t][`CNT_HI];
							cmp[t] = ~timer_decrement_source_i[t][1];
						end else begin
							tm.cnt[`CNT_HI] = tm.cnt[`CNT_HI] - 8'h01;
						end
					end
					default: begin
						if (tm.cnt == 16'h0000) begin
							tm.out = ~tm.out;
							tm.cnt = timer_compare_i[t];
							cmp[t] = 1'b1;
						end else begin
							tm.cnt = tm.cnt - 16'h0001;
						end
					end
				endcase
			end
			tm.trig_q = trg;
			tm.pin_q = dpin;
			// Event flag: set wins over clear
			tm.flag = (tm.flag & ~timer_event_clear_i[t]) | cmp[t];
			// Shift clock edges, not counted on the start cycle
			rise[t] = state_reg.tmr[t].en & tm.out & ~state_reg.tmr[t].out;
			fall[t] = state_reg.tmr[t].en & ~tm.out & state_reg.tmr[t].out;
			state_next.tmr[t] = tm;
		end

		// Shifters
		for (int s = 0; s < `SC_NSHF; s++) begin
			sh = state_reg.shf[s];
			ts = shifter_timer_select_i[s];
			set_rdy = 1'b0;
			set_flt = 1'b0;
			chk_st = shifter_start_bit_setting_i[s][`BIT_SET_EN] & timer_start_bit_setting_i[ts] &
				(timer_operating_mode_i[ts] != `TMR_MODE_PWM);
			chk_sp = shifter_stop_bit_setting_i[s][`BIT_SET_EN] & timer_stop_bit_setting_i[ts] &
				(timer_operating_mode_i[ts] != `TMR_MODE_PWM);
			if (shifter_mode_i[s] == `SHF_MODE_TX) begin
				if (sh.mode_q != `SHF_MODE_TX) begin
					set_rdy = 1'b1;
					sh.out = shifter_stop_bit_setting_i[s][`BIT_SET_EN] ?
						shifter_stop_bit_setting_i[s][`BIT_SET_VAL] : 1'b1;
				end else if (cmp[ts]) begin
					if (tx_avail[s]) begin
						tx_pop[s] = 1'b1;
						set_rdy = 1'b1;
						if (shifter_start_bit_setting_i[s][`BIT_SET_EN]) begin
							sh.out = shifter_start_bit_setting_i[s][`BIT_SET_VAL];
							sh.sreg = tx_word[s];
						end else begin
							sh.out = tx_word[s][0];
							sh.sreg = {shifter_stop_bit_setting_i[s][`BIT_SET_VAL], tx_word[s][`SC_DATA_W-1:1]};
						end
					end else begin
						set_flt = 1'b1;
					end
				end else if (fall[ts]) begin
					// Shift out; stop level fills in behind the data
					sh.out = sh.sreg[0];
					sh.sreg = {shifter_stop_bit_setting_i[s][`BIT_SET_VAL], sh.sreg[`SC_DATA_W-1:1]};
				end
			end else if (shifter_mode_i[s] == `SHF_MODE_RX) begin
				if (sh.mode_q != `SHF_MODE_RX) begin
					sh.first = chk_st;
				end else begin
					if (rise[ts]) begin
						if (sh.first) begin
							sh.first = 1'b0;
							set_flt = (shf_in[s] != shifter_start_bit_setting_i[s][`BIT_SET_VAL]);
						end else begin
							sh.sreg = {shf_in[s], sh.sreg[`SC_DATA_W-1:1]};
						end
					end
					if (cmp[ts]) begin
						if (chk_sp && shf_in[s] != shifter_stop_bit_setting_i[s][`BIT_SET_VAL]) begin
							set_flt = 1'b1;
						end
						if (rx_space[s]) begin
							rx_push[s] = 1'b1;
							set_rdy = 1'b1;
						end else begin
							set_flt = 1'b1;
						end
						sh.first = chk_st;
					end
				end
				sh.out = 1'b1;
			end else begin
				sh.out = 1'b1;
				sh.first = 1'b0;
			end
			sh.mode_q = shifter_mode_i[s];
			// Flags hold until cleared; a new event beats the clear
			sh.ready = (sh.ready & ~shifter_ready_clear_i[s]) | set_rdy;
			sh.fault = (sh.fault & ~shifter_fault_clear_i[s]) | set_flt;
			state_next.shf[s] = sh;
		end

		// Halted core freezes all core state and the shifters' buffer transfers
		if (!run) begin
			state_next = state_reg;
			tx_pop = '0;
			rx_push = '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register

	// System reset and soft reset both return state to default
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_reg <= '0;
		end else if (soft_reset_request_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	// Pin drivers: transmit shifters and driving timers, enable active low
	always_comb begin
		pin_o = '0;
		pin_oe_n_o = '1;
		for (int p = 0; p < `SC_NPIN; p++) begin
			for (int s = 0; s < `SC_NSHF; s++) begin
				if (state_reg.shf[s].mode_q == `SHF_MODE_TX && shifter_pin_select_i[s] == p[2:0]) begin
					pin_o[p] = pin_o[p] | state_reg.shf[s].out;
					pin_oe_n_o[p] = 1'b0;
				end
			end
			for (int t = 0; t < `SC_NTMR; t++) begin
				if (timer_pin_drive_i[t] && timer_pin_select_i[t] == p[2:0]) begin
					pin_o[p] = pin_o[p] | state_reg.tmr[t].out;
					pin_oe_n_o[p] = 1'b0;
				end
			end
		end
	end

	// Flags, interrupts and DMA
	always_comb begin
		for (int i = 0; i < `SC_NSHF; i++) begin
			shifter_ready_flag_o[i] = state_reg.shf[i].ready;
			shifter_fault_flag_o[i] = state_reg.shf[i].fault;
			shifter_ready_irq_o[i] = state_reg.shf[i].ready & shifter_ready_irq_enable_i[i];
			shifter_fault_irq_o[i] = state_reg.shf[i].fault & shifter_fault_irq_enable_i[i];
			dma_req_o[i] = state_reg.shf[i].ready;
		end
		for (int i = 0; i < `SC_NTMR; i++) begin
			timer_event_flag_o[i] = state_reg.tmr[i].flag;
			timer_event_irq_o[i] = state_reg.tmr[i].flag & timer_event_irq_enable_i[i];
			timer_out_o[i] = state_reg.tmr[i].out;
		end
	end
endmodule // sc_serial_core
